/* cmpc_regs.svh */
// Register offsets, field positions, reset values and timing counts for the pin control block
`ifndef CMPC_REGS_SVH
`define CMPC_REGS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define CMPC_OFS_FIRST_PIN   8'h62
`define CMPC_OFS_SECOND_PIN  8'h63
`define CMPC_OFS_FLAGS       8'h60

// ---------------------------------------------------------------
// First pin control fields
// ---------------------------------------------------------------
`define CMPC_P1_FUNC_HI      7
`define CMPC_P1_FUNC_LO      4
`define CMPC_P1_DUR_BIT      2
`define CMPC_P1_IN_BIT       1
`define CMPC_P1_OUT_BIT      0

// ---------------------------------------------------------------
// Second pin control fields
// ---------------------------------------------------------------
`define CMPC_P2_FUNC_HI      7
`define CMPC_P2_FUNC_LO      4
`define CMPC_P2_OUT_BIT      3
`define CMPC_P2_IN_BIT       2
`define CMPC_P2_DUR_BIT      1

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define CMPC_RST_CTRL        8'h00

// ---------------------------------------------------------------
// Timing (times in ns, clock period in ns)
// ---------------------------------------------------------------
`define CMPC_CLK_PERIOD_NS   5
`define CMPC_PULSE_2MS_NS    2000000
`define CMPC_PULSE_175MS_NS  1750000
`define CMPC_PULSE_2MS_CYC   (`CMPC_PULSE_2MS_NS / `CMPC_CLK_PERIOD_NS)
`define CMPC_PULSE_175_CYC   (`CMPC_PULSE_175MS_NS / `CMPC_CLK_PERIOD_NS)

`endif

/* cmpc_pkg.sv */
// Types for the multifunction pin control block
package cmpc_pkg;

   // ---------------------------------------------------------------
   // Second pin function codes
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      CMPC_F_DISABLED = 4'h0,
      CMPC_F_RESERVED = 4'h1,
      CMPC_F_JACK_IRQ = 4'h2,
      CMPC_F_GP_IN    = 4'h3,
      CMPC_F_GP_OUT   = 4'h4,
      CMPC_F_DMIC_A   = 4'h5,
      CMPC_F_DMIC_B   = 4'h6,
      CMPC_F_DMIC_C   = 4'h7,
      CMPC_F_BCLK     = 4'h8,
      CMPC_F_HS_BTN   = 4'h9,
      CMPC_F_ALL4     = 4'ha,
      CMPC_F_SC_AGC   = 4'hb,
      CMPC_F_UNUSED_C = 4'hc,
      CMPC_F_HS_BTN_SC = 4'hd,
      CMPC_F_SC_ONLY  = 4'he,
      CMPC_F_BTN_ONLY = 4'hf
   } cmpc_func_t;

   // Pulse generator states
   typedef enum logic [1:0] {
      CMPC_IDLE,
      CMPC_HIGH,
      CMPC_LOW
   } cmpc_pulse_state_t;

endpackage : cmpc_pkg

/* cmpc_pin_ctrl.sv */
// Multifunction pin control: two configurable pins, register port and interrupt pulses
//
// Behaviour
// - First pin duration clear: single 2 ms pulse
// - First pin duration set: repeat until flag read
// - First pin level readable as status bit
// - First pin output follows its output bit
// - Second pin select resets to zero, disabled
// - Code two: jack detect pulse 1.75 ms
// - Codes three/four: general input/output
// - Codes five-seven: mic data, both clock edges
// - Code eight: audio bit clock in or out
// - Code nine: headset OR button interrupt
// - Code ten: OR of four interrupt sources
// - Code eleven: short-circuit OR AGC noise
// - Code thirteen: headset, button, short-circuit OR
// - Code fourteen: short-circuit interrupt only
// - Second pin duration bit: single or repeated, ignored for code two
// - Second pin output follows its output bit
// - Second pin level readable as status bit
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "cmpc_regs.svh"

module cmpc_pin_ctrl #(
   parameter int unsigned PULSE_CYC     = `CMPC_PULSE_2MS_CYC,
   parameter int unsigned JACK_CYC      = `CMPC_PULSE_175_CYC,
   parameter int unsigned CNT_W         = 19
) (
   input  wire logic       ref_clk,        // 200 MHz clock
   input  wire logic       rstn,           // Synchronous reset, active low
   input  wire logic       clk_en,         // Freezes all state when low
   input  wire logic [7:0] reg_addr,       // Register address
   input  wire logic [7:0] reg_wdata,      // Write data
   input  wire logic       reg_wr,         // Write strobe
   input  wire logic       reg_rd,         // Read strobe
   output logic      [7:0] reg_rdata,      // Read data, cycle after strobe
   input  wire logic       irq_headset,    // Headset detection event
   input  wire logic       irq_button,     // Button press event
   input  wire logic       irq_short,      // Short-circuit detection event
   input  wire logic       irq_agc_noise,  // AGC noise detection event
   input  wire logic       irq_jack,       // Jack/headset detect event
   input  wire logic       p1_irq_src,     // Interrupt source routed to first pin
   input  wire logic       p1_drive_irq,   // First pin in interrupt use
   input  wire logic       p1_drive_gpo,   // First pin in general output use
   input  wire logic       flag_read,      // Host read of interrupt flag register
   input  wire logic       dmic_clk,       // Microphone clock, sampled
   input  wire logic       bclk_is_out,    // Bit clock direction from bus setup
   input  wire logic       bclk_out,       // Bit clock to drive
   output logic            bclk_in,        // Bit clock taken from pin
   output logic      [1:0] dmic_data,      // Mic samples: [1] rising, [0] falling
   output logic            dmic_valid,     // Pulse on each mic clock edge
   output logic            gpi2,           // Second pin general input level
   input  wire logic       pin1_i,         // First pin input
   output logic            pin1_o,         // First pin output
   output logic            pin1_oe,        // First pin output enable
   input  wire logic       pin2_i,         // Second pin input
   output logic            pin2_o,         // Second pin output
   output logic            pin2_oe         // Second pin output enable
);

   if (PULSE_CYC < 2 || JACK_CYC < 2 || PULSE_CYC >= (1 << CNT_W) ||
       JACK_CYC >= (1 << CNT_W)) begin : g_bad_cnt
      $error("cmpc_pin_ctrl: pulse counts do not fit");
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   logic [7:0] p1_ctrl;
   logic [7:0] p2_ctrl;
   cmpc_pkg::cmpc_func_t p2_func;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         p1_ctrl <= `CMPC_RST_CTRL;
      end else if (clk_en && reg_wr && reg_addr == `CMPC_OFS_FIRST_PIN) begin
         p1_ctrl <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         p2_ctrl <= `CMPC_RST_CTRL;
      end else if (clk_en && reg_wr && reg_addr == `CMPC_OFS_SECOND_PIN) begin
         // Read-only and reserved bits are not stored
         p2_ctrl <= {reg_wdata[`CMPC_P2_FUNC_HI:`CMPC_P2_FUNC_LO],
                     reg_wdata[`CMPC_P2_OUT_BIT], 1'b0,
                     reg_wdata[`CMPC_P2_DUR_BIT], 1'b0};
      end
   end

   assign p2_func = cmpc_pkg::cmpc_func_t'(p2_ctrl[`CMPC_P2_FUNC_HI:`CMPC_P2_FUNC_LO]);

   // ---------------------------------------------------------------
   // Pin level sampling
   // ---------------------------------------------------------------
   logic pin1_lvl;
   logic pin2_lvl;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         pin1_lvl <= 1'b0;
         pin2_lvl <= 1'b0;
      end else if (clk_en) begin
         pin1_lvl <= pin1_i;
         pin2_lvl <= pin2_i;
      end
   end

   // ---------------------------------------------------------------
   // Register read port
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            unique case (reg_addr)
               `CMPC_OFS_FIRST_PIN: begin
                  reg_rdata <= p1_ctrl;
                  reg_rdata[`CMPC_P1_IN_BIT] <= pin1_lvl;
               end
               `CMPC_OFS_SECOND_PIN: begin
                  reg_rdata <= p2_ctrl;
                  reg_rdata[`CMPC_P2_IN_BIT] <= pin2_lvl;
               end
               default: reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Second pin interrupt source select
   // ---------------------------------------------------------------
   logic p2_src;
   logic p2_is_irq;

   always_comb begin
      p2_is_irq = 1'b1;
      unique case (p2_func)
         cmpc_pkg::CMPC_F_JACK_IRQ:  p2_src = irq_jack;
         cmpc_pkg::CMPC_F_HS_BTN:    p2_src = irq_headset | irq_button;
         cmpc_pkg::CMPC_F_ALL4:      p2_src = irq_headset | irq_button |
                                               irq_short | irq_agc_noise;
         cmpc_pkg::CMPC_F_SC_AGC:    p2_src = irq_short | irq_agc_noise;
         cmpc_pkg::CMPC_F_HS_BTN_SC: p2_src = irq_headset | irq_button |
                                               irq_short;
         cmpc_pkg::CMPC_F_SC_ONLY:   p2_src = irq_short;
         cmpc_pkg::CMPC_F_BTN_ONLY:  p2_src = irq_button;
         default: begin
            p2_src    = 1'b0;
            p2_is_irq = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Interrupt pulse generators
   // ---------------------------------------------------------------
   logic p1_pulse;
   logic p2_pulse;
   logic p2_jack;

   assign p2_jack = (p2_func == cmpc_pkg::CMPC_F_JACK_IRQ);

   cmpc_pulse #(.CNT_W(CNT_W)) u_p1_pulse (
      .ref_clk   (ref_clk),
      .rstn      (rstn),
      .clk_en    (clk_en),
      .enable    (p1_drive_irq),
      .trig      (p1_irq_src),
      .repeat_en (p1_ctrl[`CMPC_P1_DUR_BIT]),
      .stop      (flag_read),
      .len       (CNT_W'(PULSE_CYC)),
      .pulse     (p1_pulse)
   );

   cmpc_pulse #(.CNT_W(CNT_W)) u_p2_pulse (
      .ref_clk   (ref_clk),
      .rstn      (rstn),
      .clk_en    (clk_en),
      .enable    (p2_is_irq),
      .trig      (p2_src),
      .repeat_en (p2_ctrl[`CMPC_P2_DUR_BIT] & ~p2_jack),
      .stop      (flag_read),
      .len       (p2_jack ? CNT_W'(JACK_CYC) : CNT_W'(PULSE_CYC)),
      .pulse     (p2_pulse)
   );

   // ---------------------------------------------------------------
   // Digital microphone capture on both clock edges
   // ---------------------------------------------------------------
   logic dmic_clk_d;
   logic dmic_sel;

   assign dmic_sel = (p2_func == cmpc_pkg::CMPC_F_DMIC_A) ||
                     (p2_func == cmpc_pkg::CMPC_F_DMIC_B) ||
                     (p2_func == cmpc_pkg::CMPC_F_DMIC_C);

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         dmic_clk_d <= 1'b0;
         dmic_data  <= 2'h0;
         dmic_valid <= 1'b0;
      end else if (clk_en) begin
         dmic_clk_d <= dmic_clk;
         dmic_valid <= 1'b0;
         if (dmic_sel && dmic_clk != dmic_clk_d) begin
            dmic_valid <= 1'b1;
            if (dmic_clk)
               dmic_data[1] <= pin2_i;
            else
               dmic_data[0] <= pin2_i;
         end
      end
   end

   // ---------------------------------------------------------------
   // Second pin general input and bit clock input
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         gpi2    <= 1'b0;
         bclk_in <= 1'b0;
      end else if (clk_en) begin
         if (p2_func == cmpc_pkg::CMPC_F_GP_IN)
            gpi2 <= pin2_i;
         if (p2_func == cmpc_pkg::CMPC_F_BCLK && !bclk_is_out)
            bclk_in <= pin2_i;
      end
   end

   // ---------------------------------------------------------------
   // Pin drivers
   // ---------------------------------------------------------------
   // Reserved code one and the disabled/input codes leave the pin undriven
   always_comb begin
      pin2_o  = 1'b0;
      pin2_oe = 1'b0;
      if (p2_func == cmpc_pkg::CMPC_F_GP_OUT) begin
         pin2_o  = p2_ctrl[`CMPC_P2_OUT_BIT];
         pin2_oe = 1'b1;
      end else if (p2_func == cmpc_pkg::CMPC_F_BCLK && bclk_is_out) begin
         pin2_o  = bclk_out;
         pin2_oe = 1'b1;
      end else if (p2_is_irq) begin
         pin2_o  = p2_pulse;
         pin2_oe = 1'b1;
      end
   end

   always_comb begin
      pin1_o  = 1'b0;
      pin1_oe = 1'b0;
      if (p1_drive_gpo) begin
         pin1_o  = p1_ctrl[`CMPC_P1_OUT_BIT];
         pin1_oe = 1'b1;
      end else if (p1_drive_irq) begin
         pin1_o  = p1_pulse;
         pin1_oe = 1'b1;
      end
   end

endmodule : cmpc_pin_ctrl

// ---------------------------------------------------------------
// Interrupt pulse generator
// ---------------------------------------------------------------
// Single pulse of len cycles per rising trigger, or high/low pulses
// of len cycles each until stop when repeat_en is set
module cmpc_pulse #(
   parameter int unsigned CNT_W = 19
) (
   input  wire logic             ref_clk,    // Clock
   input  wire logic             rstn,       // Synchronous reset, active low
   input  wire logic             clk_en,     // Clock enable
   input  wire logic             enable,     // Pin in interrupt use
   input  wire logic             trig,       // Interrupt source level
   input  wire logic             repeat_en,  // Repeat until stop
   input  wire logic             stop,       // Host read of flag register
   input  wire logic [CNT_W-1:0] len,        // Pulse length in cycles
   output logic                  pulse       // Pulse output
);

   cmpc_pkg::cmpc_pulse_state_t state;
   logic [CNT_W-1:0] cnt;
   logic             trig_d;
   logic             stopped;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state   <= cmpc_pkg::CMPC_IDLE;
         cnt     <= '0;
         trig_d  <= 1'b0;
         stopped <= 1'b0;
      end else if (clk_en) begin
         trig_d <= trig;
         if (!enable) begin
            state <= cmpc_pkg::CMPC_IDLE;
         end else begin
            unique case (state)
               cmpc_pkg::CMPC_IDLE: begin
                  stopped <= 1'b0;
                  if (trig && !trig_d) begin
                     state <= cmpc_pkg::CMPC_HIGH;
                     cnt   <= len - 1'b1;
                  end
               end
               cmpc_pkg::CMPC_HIGH: begin
                  if (stop) stopped <= 1'b1;
                  if (cnt == '0) begin
                     state <= (repeat_en && !stopped && !stop) ?
                              cmpc_pkg::CMPC_LOW : cmpc_pkg::CMPC_IDLE;
                     cnt   <= len - 1'b1;
                  end else begin
                     cnt <= cnt - 1'b1;
                  end
               end
               cmpc_pkg::CMPC_LOW: begin
                  if (stop) stopped <= 1'b1;
                  if (cnt == '0) begin
                     state <= (stopped || stop) ? cmpc_pkg::CMPC_IDLE
                                                : cmpc_pkg::CMPC_HIGH;
                     cnt   <= len - 1'b1;
                  end else begin
                     cnt <= cnt - 1'b1;
                  end
               end
               default: state <= cmpc_pkg::CMPC_IDLE;
            endcase
         end
      end
   end

   assign pulse = (state == cmpc_pkg::CMPC_HIGH);

endmodule : cmpc_pulse

/* cmpc_pin_ctrl_properties.sv */
// Port-level checker for the multifunction pin control block
`timescale 1ns/1ps
`include "cmpc_regs.svh"
module cmpc_pin_ctrl_properties #(
   parameter int unsigned PULSE_CYC = 8
) (
   input wire logic       ref_clk,       // Clock
   input wire logic       rstn,          // Reset, active low
   input wire logic       clk_en,        // Clock enable
   input wire logic [7:0] reg_addr,      // Register address
   input wire logic [7:0] reg_wdata,     // Write data
   input wire logic       reg_wr,        // Write strobe
   input wire logic       reg_rd,        // Read strobe
   input wire logic [7:0] reg_rdata,     // Read data
   input wire logic       p1_drive_irq,  // First pin interrupt use
   input wire logic       p1_drive_gpo,  // First pin output use
   input wire logic       bclk_is_out,   // Bit clock direction
   input wire logic       bclk_out,      // Bit clock to drive
   input wire logic       dmic_valid,    // Mic sample strobe
   input wire logic       pin1_i,        // First pin wire
   input wire logic       pin1_o,        // First pin output
   input wire logic       pin1_oe,       // First pin enable
   input wire logic       pin2_i,        // Second pin wire
   input wire logic       pin2_o,        // Second pin output
   input wire logic       pin2_oe        // Second pin enable
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   logic        irq1;
   logic        wr1;
   logic        wr2;
   int unsigned hi_cnt;
   assign irq1 = p1_drive_irq && !p1_drive_gpo;
   assign wr1  = reg_wr && clk_en && reg_addr == `CMPC_OFS_FIRST_PIN;
   assign wr2  = reg_wr && clk_en && reg_addr == `CMPC_OFS_SECOND_PIN;
   // Length of the running high phase on the first pin
   always_ff @(posedge ref_clk) begin
      if (!rstn || !irq1 || !pin1_o) begin
         hi_cnt <= 0;
      end else begin
         hi_cnt <= hi_cnt + 1;
      end
   end
   a_p1_out_level: assert property (
      wr1 && p1_drive_gpo |=> !p1_drive_gpo || (pin1_oe && pin1_o == $past(reg_wdata[0])))
      else $error("first pin output differs from written value");
   a_p2_out_level: assert property (
      wr2 && reg_wdata[7:4] == 4'h4 |=> pin2_oe && pin2_o == $past(reg_wdata[3]))
      else $error("second pin output differs from written value");
   a_p2_not_driven: assert property (
      wr2 && reg_wdata[7:4] inside {4'h0, 4'h1, 4'h3, 4'h5, 4'h6, 4'h7, 4'hc} |=> !pin2_oe)
      else $error("second pin driven while disabled or input");
   a_p1_not_driven: assert property (
      (!p1_drive_gpo && !p1_drive_irq) [*2] |-> !pin1_oe)
      else $error("first pin driven while unused");
   a_p1_level_read: assert property (
      reg_rd && clk_en && reg_addr == `CMPC_OFS_FIRST_PIN && $stable(pin1_i) && $past(rstn, 2)
      |=> reg_rdata[1] == $past(pin1_i))
      else $error("first pin level read back wrong");
   a_p2_level_read: assert property (
      reg_rd && clk_en && reg_addr == `CMPC_OFS_SECOND_PIN && $stable(pin2_i) && $past(rstn, 2)
      |=> reg_rdata[2] == $past(pin2_i))
      else $error("second pin level read back wrong");
   a_p1_pulse_len: assert property (
      irq1 && $past(irq1) && $fell(pin1_o) |-> hi_cnt == PULSE_CYC)
      else $error("first pin pulse length wrong");
   a_bclk_dir: assert property (
      wr2 && reg_wdata[7:4] == 4'h8
      |=> pin2_oe == bclk_is_out && (!bclk_is_out || pin2_o == bclk_out))
      else $error("bit clock direction or level wrong");
   cover property (irq1 && $rose(pin1_o));
   cover property (dmic_valid);
   cover property (pin2_oe && $rose(pin2_o));
endmodule : cmpc_pin_ctrl_properties

/* cmpc_pin_host.sv */
// Host-side model of both pin wires
`timescale 1ns/1ps
module cmpc_pin_host (
   input  wire logic ref_clk,  // Clock
   input  wire logic pin1_o,   // Block drive, first pin
   input  wire logic pin1_oe,  // Block enable, first pin
   input  wire logic pin2_o,   // Block drive, second pin
   input  wire logic pin2_oe,  // Block enable, second pin
   input  wire logic d1_en,    // Host drives first pin
   input  wire logic d1_val,   // Host level, first pin
   input  wire logic d2_en,    // Host drives second pin
   input  wire logic d2_val,   // Host level, second pin
   output logic      pin1_i,   // Resolved first wire
   output logic      pin2_i    // Resolved second wire
);
   logic flip = 1'b0;
   // A floating wire toggles so that a stale level never reads as valid
   always @(posedge ref_clk) flip <= ~flip;
   assign pin1_i = pin1_oe ? pin1_o : (d1_en ? d1_val : flip);
   assign pin2_i = pin2_oe ? pin2_o : (d2_en ? d2_val : flip);
endmodule : cmpc_pin_host

/* cmpc_pin_ctrl_tb.sv */
// Self-checking testbench for the multifunction pin control block
`timescale 1ns/1ps
`include "cmpc_regs.svh"
module cmpc_pin_ctrl_tb;
   localparam int unsigned PULSE = 8;
   localparam int unsigned JACK  = 6;
   logic ref_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [4:0] irq_v = 5'h00;
   logic p1_src = 1'b0, p1_irq = 1'b0, p1_gpo = 1'b0, flag_read = 1'b0, dmic_clk = 1'b0;
   logic bclk_is_out = 1'b0, bclk_out = 1'b0, bclk_in, dmic_valid, gpi2;
   logic d1_en = 1'b0, d1_val = 1'b0, d2_en = 1'b1, d2_val = 1'b0;
   logic [1:0] dmic_data;
   logic pin1_i, pin1_o, pin1_oe, pin2_i, pin2_o, pin2_oe;
   int miscompares = 0, num_checks = 0, cycles = 0, nvalid = 0;
   cmpc_pin_ctrl #(.PULSE_CYC(PULSE), .JACK_CYC(JACK)) cmpc_pin_ctrl_i (.ref_clk, .rstn,
      .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_headset(irq_v[0]),
      .irq_button(irq_v[1]), .irq_short(irq_v[2]), .irq_agc_noise(irq_v[3]),
      .irq_jack(irq_v[4]), .p1_irq_src(p1_src), .p1_drive_irq(p1_irq),
      .p1_drive_gpo(p1_gpo), .flag_read, .dmic_clk, .bclk_is_out, .bclk_out, .bclk_in,
      .dmic_data, .dmic_valid, .gpi2, .pin1_i, .pin1_o, .pin1_oe, .pin2_i, .pin2_o, .pin2_oe);
   cmpc_pin_host cmpc_pin_host_i (.ref_clk, .pin1_o, .pin1_oe, .pin2_o, .pin2_oe, .d1_en,
      .d1_val, .d2_en, .d2_val, .pin1_i, .pin2_i);
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (dmic_valid === 1'b1) nvalid++;
      // Whole run needs about 1900 cycles
      if (cycles == 20000) begin
         miscompares++;
         conclude();
      end
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic observe(input bit p2, input int n, output int hi, output int rises);
      logic last;
      hi = 0;
      rises = 0;
      last = 1'b0;
      repeat (n) begin
         cyc(1);
         if ((p2 ? pin2_o : pin1_o) === 1'b1) begin
            hi++;
            if (!last) rises++;
         end
         last = p2 ? pin2_o : pin1_o;
      end
   endtask : observe
   task automatic t_reset;
      logic [7:0] d;
      logic [3:0] codes [3] = '{4'h0, 4'h3, 4'hc};
      rd(`CMPC_OFS_SECOND_PIN, d);
      check("second ctrl reset", 8'h00, d);
      wr(8'h70, 8'hff);
      rd(8'h70, d);
      check("unmapped read", 8'h00, d);
      // Reserved code one is never written by the host
      foreach (codes[i]) begin
         wr(`CMPC_OFS_SECOND_PIN, {codes[i], 4'h8});
         cyc(1);
         check("pin2 oe idle", 8'h00, {7'h0, pin2_oe});
      end
      $display("t_reset done");
   endtask : t_reset
   task automatic t_gpio;
      logic [7:0] d;
      p1_gpo <= 1'b1;
      for (int v = 0; v < 2; v++) begin
         wr(`CMPC_OFS_FIRST_PIN, 8'(v));
         wr(`CMPC_OFS_SECOND_PIN, {4'h4, 1'(v), 3'h0});
         cyc(1);
         check("pin1 drive", {6'h0, 1'b1, 1'(v)}, {6'h0, pin1_oe, pin1_o});
         check("pin2 drive", {6'h0, 1'b1, 1'(v)}, {6'h0, pin2_oe, pin2_o});
         rd(`CMPC_OFS_SECOND_PIN, d);
         check("pin2 readback", {4'h4, 1'(v), 1'(v), 2'h0}, d);
      end
      p1_gpo <= 1'b0;
      d1_en <= 1'b1;
      wr(`CMPC_OFS_SECOND_PIN, 8'h30);
      for (int v = 1; v >= 0; v--) begin
         d1_val <= 1'(v);
         d2_val <= 1'(v);
         cyc(3);
         check("pin2 input", {6'h0, 1'b0, 1'(v)}, {6'h0, pin2_oe, gpi2});
         rd(`CMPC_OFS_SECOND_PIN, d);
         check("pin2 level", {4'h3, 1'b0, 1'(v), 2'h0}, d);
         rd(`CMPC_OFS_FIRST_PIN, d);
         check("pin1 level", {6'h0, 1'(v), 1'b1}, d);
      end
      $display("t_gpio done");
   endtask : t_gpio
   task automatic t_irq;
      logic [3:0] codes [7] = '{4'h2, 4'h9, 4'ha, 4'hb, 4'hd, 4'he, 4'hf};
      logic [4:0] m;
      logic [7:0] e;
      int hi, r;
      p1_irq <= 1'b1;
      wr(`CMPC_OFS_FIRST_PIN, 8'h00);
      p1_src <= 1'b1;
      observe(1'b0, 30, hi, r);
      check("pin1 single pulse", 8'(PULSE), 8'(hi));
      p1_src <= 1'b0;
      foreach (codes[i]) begin
         case (codes[i])
            4'h2: m = 5'h10;
            4'h9: m = 5'h03;
            4'ha: m = 5'h0f;
            4'hb: m = 5'h0c;
            4'hd: m = 5'h07;
            4'he: m = 5'h04;
            default: m = 5'h02;
         endcase
         wr(`CMPC_OFS_SECOND_PIN, {codes[i], 4'h0});
         for (int s = 0; s < 5; s++) begin
            irq_v <= 5'h01 << s;
            observe(1'b1, 30, hi, r);
            irq_v <= 5'h00;
            cyc(12);
            e = m[s] ? 8'(i == 0 ? JACK : PULSE) : 8'h00;
            check("pin2 pulse", e, 8'(hi));
         end
      end
      $display("t_irq done");
   endtask : t_irq
   task automatic t_repeat(input bit p2);
      int hi, r;
      wr(p2 ? `CMPC_OFS_SECOND_PIN : `CMPC_OFS_FIRST_PIN, p2 ? 8'h92 : 8'h04);
      if (p2) irq_v <= 5'h01;
      else p1_src <= 1'b1;
      observe(p2, 60, hi, r);
      check("repeat rises", 8'h01, 8'(r >= 3));
      @(posedge ref_clk);
      flag_read <= 1'b1;
      @(posedge ref_clk);
      flag_read <= 1'b0;
      observe(p2, 20, hi, r);
      observe(p2, 40, hi, r);
      check("quiet after flag read", 8'h00, 8'(hi));
      irq_v <= 5'h00;
      p1_src <= 1'b0;
      $display("t_repeat done");
   endtask : t_repeat
   task automatic t_dmic;
      for (int c = 5; c < 8; c++) begin
         wr(`CMPC_OFS_SECOND_PIN, {4'(c), 4'h0});
         d2_val <= 1'b1;
         cyc(2);
         nvalid = 0;
         dmic_clk <= 1'b1;
         cyc(6);
         d2_val <= 1'b0;
         cyc(2);
         dmic_clk <= 1'b0;
         cyc(6);
         check("mic samples", 8'h02, {6'h0, dmic_data});
         check("mic strobes", 8'h02, 8'(nvalid));
         check("mic pin oe", 8'h00, {7'h0, pin2_oe});
      end
      $display("t_dmic done");
   endtask : t_dmic
   task automatic t_bclk;
      wr(`CMPC_OFS_SECOND_PIN, 8'h80);
      bclk_is_out <= 1'b1;
      for (int v = 0; v < 2; v++) begin
         bclk_out <= 1'(v);
         cyc(1);
         check("bclk drive", {6'h0, 1'b1, 1'(v)}, {6'h0, pin2_oe, pin2_o});
      end
      bclk_is_out <= 1'b0;
      d2_val <= 1'b1;
      cyc(3);
      check("bclk input", 8'h01, {6'h0, pin2_oe, bclk_in});
      $display("t_bclk done");
   endtask : t_bclk
   initial begin
      repeat (20) @(posedge ref_clk);
      rstn <= 1'b1;
      cyc(2);
      t_reset();
      t_gpio();
      t_irq();
      t_repeat(1'b0);
      t_repeat(1'b1);
      t_dmic();
      t_bclk();
      conclude();
   end
endmodule : cmpc_pin_ctrl_tb
bind cmpc_pin_ctrl cmpc_pin_ctrl_properties #(.PULSE_CYC(PULSE_CYC)) cmpc_pin_ctrl_properties_i (
   .ref_clk, .rstn, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .p1_drive_irq,
   .p1_drive_gpo, .bclk_is_out, .bclk_out, .dmic_valid, .pin1_i, .pin1_o, .pin1_oe, .pin2_i,
   .pin2_o, .pin2_oe);
